// File: src/rpic_map.vh
/*
 * register map, field positions and reset values of the rotating
 * priority interrupt controller; included by the top design file only.
 */
`ifndef RPIC_MAP_VH
`define RPIC_MAP_VH

// byte offsets inside the controller window
`define RPIC_OFF_SRC_PEND 12'h000
`define RPIC_OFF_FAST_SEL 12'h004
`define RPIC_OFF_MASK 12'h008
`define RPIC_OFF_PRIO 12'h00c
`define RPIC_OFF_ARB_PEND 12'h010
`define RPIC_OFF_WIN_IDX 12'h014

// reset values
`define RPIC_RST_SRC_PEND 32'h00000000
`define RPIC_RST_FAST_SEL 32'h00000000
`define RPIC_RST_MASK 32'hffffffff
`define RPIC_RST_PRIO 32'h00000000
`define RPIC_RST_ARB_PEND 32'h00000000

// priority register fields: rotate enable bit i, select at 2i+8
`define RPIC_PRIO_ROT_LSB 0
`define RPIC_PRIO_SEL_LSB 8
`define RPIC_PRIO_USED 32'h003fff7f

// source positions with special handling
`define RPIC_SRC_SERIAL_ERR 15
`define RPIC_SRC_RESERVED 16

`endif

// File: src/rpic_arbiter.v
/*
 * six-input arbiter with a four-way rotatable middle band.
 * assumes the priority select is held by the caller.
 */
`timescale 1ns/100ps
`default_nettype none

module rpic_arbiter
(
  input wire [5:0] req, // request inputs 0..5
  input wire [1:0] sel, // priority select
  output reg hit, // some input requests
  output reg [2:0] pick // winning input
);

  integer k;
  reg [2:0] idx;

  // input 0 first, then rotated band 1..4, input 5 last
  always @*
  begin
    idx = 3'h0;
    hit = |req;
    pick = 3'h5;
    if (req[0])
    begin
      pick = 3'h0;
    end
    else
    begin
      for (k = 3; k >= 0; k = k - 1)
      begin
        idx = {1'b0, sel + k[1:0]} + 3'h1;
        if (req[idx])
        begin
          pick = idx;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: src/rpic_top.v
/*
 * rotating priority interrupt controller with an apb register port.
 * assumes synchronous source levels on pclk and an apb master.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
// How it works
// - thirty-two source inputs, peripherals and external pins
// - both serial error requests are ored into one source
// - winner drives the normal line; fast sources drive the fast line
// - a requesting source sets its source pending bit
// - arbitration sets exactly one arbitrated pending bit for the winner
// - mask one excludes a source from arbitration, pending still sets
// - both pending registers read and clear by writing ones
// - sources fall into six first-level groups: 0-3, 4-9, 10-15, 16-21, 22-27, 28-31
// - six first-level arbiters plus one second-level arbiter
// - each arbiter has six inputs, rotate enable and two-bit select
// - select picks one of four orders for inputs one to four
// - input zero always highest, input five always lowest
// - rotate enable zero keeps select fixed, software may rewrite
// - rotate enable one moves serviced input to lowest of band
// - servicing input zero or five leaves select unchanged
// - fast select one routes to fast line; write-only, resets zero
// - fast sources never touch arbitrated pending or winner index
// - source pending write clears only bits written as one
`timescale 1ns/100ps
`default_nettype none
`include "rpic_map.vh"

module rpic_top
#(
  parameter ADDR_W = 12
)
(
  input wire pclk, // bus clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb transfer done
  output reg pslverr, // unmapped address
  input wire [31:0] src_req, // source levels, bits 15 and 16 unused
  input wire serial_err0, // serial port 0 error
  input wire serial_err1, // serial port 1 error
  output reg fast_irq, // fast request to core
  output reg normal_irq // normal request to core
);

  // held state and next values
  reg [31:0] source_pending_bits_reg;
  reg [31:0] source_pending_bits_next;
  reg [31:0] fast_mode_select_reg;
  reg [31:0] source_mask_bits_reg;
  reg [31:0] prio_reg;
  reg [31:0] prio_next;
  reg [31:0] arbitrated_pending_bits_reg;
  reg [31:0] arbitrated_pending_bits_next;
  reg [4:0] win_idx_reg;

  // candidate vector and arbiter tree
  wire [31:0] src_in;
  wire [31:0] cand;
  wire [35:0] lanes;
  wire [5:0] grp_hit;
  wire [17:0] grp_pick;
  wire top_hit;
  wire [2:0] top_pick;
  reg [2:0] win_inp;
  wire [4:0] win_src;
  wire do_arb;

  // bus decode and read mux
  wire acc;
  wire wr_done;
  reg [31:0] rd_data;

  // true for any offset inside the map
  // anything else, unaligned ones too, answers with an error
  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a == `RPIC_OFF_SRC_PEND) || (a == `RPIC_OFF_FAST_SEL) ||
        (a == `RPIC_OFF_MASK) || (a == `RPIC_OFF_PRIO) ||
        (a == `RPIC_OFF_ARB_PEND) || (a == `RPIC_OFF_WIN_IDX);
    end
  endfunction

  // group and input back to source bit
  function [4:0] src_of;
    input [2:0] grp;
    input [2:0] inp;
    reg [5:0] s;
    begin
      s = (grp == 3'h0) ? {3'h0, inp} : ({grp, 2'b00} + {1'b0, grp, 1'b0} + {3'h0, inp} - 6'h2);
      src_of = s[4:0];
    end
  endfunction

  // select after servicing an input
  // inputs 0 and 5 leave the select alone
  function [1:0] sel_after;
    input [1:0] sel;
    input [2:0] inp;
    input rot;
    begin
      sel_after = sel;
      if (rot)
      begin
        case (inp)
          3'h1: sel_after = 2'b01;
          3'h2: sel_after = 2'b10;
          3'h3: sel_after = 2'b11;
          3'h4: sel_after = 2'b00;
          default: sel_after = sel;
        endcase
      end
    end
  endfunction

  // source vector with shared serial error and dead reserved slot
  // the reserved slot can never become pending
  assign src_in = {src_req[31:17], 1'b0, serial_err0 | serial_err1, src_req[14:0]};

  // candidates: pending, unmasked, normal mode only
  // fast sources stay out of the tree and the winner index
  assign cand = source_pending_bits_reg & ~source_mask_bits_reg & ~fast_mode_select_reg;
  assign lanes = {2'b00, cand[31:4], 2'b00, cand[3:0]};

  // first-level arbiters
  // group g takes lanes 6g to 6g+5
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : grp
      rpic_arbiter u_arb
      (
        .req(lanes[6*g+5:6*g]),
        .sel(prio_reg[`RPIC_PRIO_SEL_LSB+2*g+1:`RPIC_PRIO_SEL_LSB+2*g]),
        .hit(grp_hit[g]),
        .pick(grp_pick[3*g+2:3*g])
      );
    end
  endgenerate

  // second-level arbiter over group winners
  rpic_arbiter u_top
  (
    .req(grp_hit),
    .sel(prio_reg[`RPIC_PRIO_SEL_LSB+13:`RPIC_PRIO_SEL_LSB+12]),
    .hit(top_hit),
    .pick(top_pick)
  );

  // winning input within the winning group
  // only the second-level winner's group matters
  always @*
  begin
    case (top_pick)
      3'h0: win_inp = grp_pick[2:0];
      3'h1: win_inp = grp_pick[5:3];
      3'h2: win_inp = grp_pick[8:6];
      3'h3: win_inp = grp_pick[11:9];
      3'h4: win_inp = grp_pick[14:12];
      3'h5: win_inp = grp_pick[17:15];
      default: win_inp = 3'h0;
    endcase
  end

  assign win_src = src_of(top_pick, win_inp);
  // a new winner only while nothing awaits service
  // keeps the arbitrated bits one-hot between services
  assign do_arb = top_hit & ~(|arbitrated_pending_bits_reg);

  // apb phases: one wait state, write lands on the ready edge
  // pready pulses for one cycle after the first access cycle
  assign acc = psel & penable;
  assign wr_done = acc & pready & pwrite & mapped(paddr);

  // source pending: write-one clear, set wins
  // a held source level re-sets a bit in its clearing cycle
  always @*
  begin
    source_pending_bits_next = source_pending_bits_reg;
    if (wr_done && paddr == `RPIC_OFF_SRC_PEND)
    begin
      source_pending_bits_next = source_pending_bits_reg & ~pwdata;
    end
    source_pending_bits_next = source_pending_bits_next | src_in;
  end

  // arbitrated pending: write-one clear, one-hot set on arbitration
  always @*
  begin
    arbitrated_pending_bits_next = arbitrated_pending_bits_reg;
    if (wr_done && paddr == `RPIC_OFF_ARB_PEND)
    begin
      arbitrated_pending_bits_next = arbitrated_pending_bits_reg & ~pwdata;
    end
    if (do_arb)
    begin
      arbitrated_pending_bits_next = arbitrated_pending_bits_next | (32'h00000001 << win_src);
    end
  end

  // priority select rotation; a software write takes precedence
  // only the winning group and the second level move
  always @*
  begin
    prio_next = prio_reg;
    if (do_arb)
    begin
      case (top_pick)
        3'h0: prio_next[9:8] = sel_after(prio_reg[9:8], win_inp, prio_reg[0]);
        3'h1: prio_next[11:10] = sel_after(prio_reg[11:10], win_inp, prio_reg[1]);
        3'h2: prio_next[13:12] = sel_after(prio_reg[13:12], win_inp, prio_reg[2]);
        3'h3: prio_next[15:14] = sel_after(prio_reg[15:14], win_inp, prio_reg[3]);
        3'h4: prio_next[17:16] = sel_after(prio_reg[17:16], win_inp, prio_reg[4]);
        3'h5: prio_next[19:18] = sel_after(prio_reg[19:18], win_inp, prio_reg[5]);
        default: prio_next = prio_reg;
      endcase
      prio_next[21:20] = sel_after(prio_reg[21:20], top_pick, prio_reg[6]);
    end
    if (wr_done && paddr == `RPIC_OFF_PRIO)
    begin
      prio_next = pwdata & `RPIC_PRIO_USED;
    end
  end

  // read mux; fast select reads as zero
  always @*
  begin
    case (paddr)
      `RPIC_OFF_SRC_PEND: rd_data = source_pending_bits_reg;
      `RPIC_OFF_MASK: rd_data = source_mask_bits_reg;
      `RPIC_OFF_PRIO: rd_data = prio_reg;
      `RPIC_OFF_ARB_PEND: rd_data = arbitrated_pending_bits_reg;
      `RPIC_OFF_WIN_IDX: rd_data = {27'h0000000, win_idx_reg};
      default: rd_data = 32'h00000000;
    endcase
  end

  // state registers
  // mask resets to all ones so nothing fires before setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      source_pending_bits_reg <= `RPIC_RST_SRC_PEND;
      fast_mode_select_reg <= `RPIC_RST_FAST_SEL;
      source_mask_bits_reg <= `RPIC_RST_MASK;
      prio_reg <= `RPIC_RST_PRIO;
      arbitrated_pending_bits_reg <= `RPIC_RST_ARB_PEND;
      win_idx_reg <= 5'h00;
    end
    else
    begin
      source_pending_bits_reg <= source_pending_bits_next;
      arbitrated_pending_bits_reg <= arbitrated_pending_bits_next;
      prio_reg <= prio_next;
      if (do_arb)
      begin
        win_idx_reg <= win_src;
      end
      if (wr_done && paddr == `RPIC_OFF_FAST_SEL)
      begin
        fast_mode_select_reg <= pwdata;
      end
      if (wr_done && paddr == `RPIC_OFF_MASK)
      begin
        source_mask_bits_reg <= pwdata;
      end
    end
  end

  // apb answer and core request lines
  // both core lines lag their pending state by one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      fast_irq <= 1'b0;
      normal_irq <= 1'b0;
    end
    else
    begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped(paddr);
      if (acc && !pready && !pwrite)
      begin
        prdata <= rd_data;
      end
      fast_irq <= |(source_pending_bits_reg & fast_mode_select_reg & ~source_mask_bits_reg);
      normal_irq <= |arbitrated_pending_bits_reg;
    end
  end

endmodule

`default_nettype wire

// File: dv/rpic_chk_asserts.sv
/* port checker for rpic_top.
   assumes a bind into rpic_top, one pclk domain. */
`timescale 1ns/100ps
`default_nettype none
module rpic_chk
#(
  parameter ADDR_W = 12
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // done
  input wire logic pslverr, // error
  input wire logic fast_irq, // fast line
  input wire logic normal_irq // normal line
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rd, bad;
  // first access cycle, read, unmapped offset
  assign acc = psel && penable && !pready;
  assign rd = acc && !pwrite;
  assign bad = paddr > 'h14 || paddr[1:0] != 2'h0;
  a_ready_wait: assert property (acc |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_unmapped_err: assert property (acc && bad |=> pslverr) else $error("no pslverr");
  a_mapped_ok: assert property (acc && !bad |=> !pslverr) else $error("bad pslverr");
  a_fast_hidden: assert property (rd && paddr == 'h4 |=> prdata == 0) else $error("mode read");
  a_win_range: assert property (rd && paddr == 'h14 |=> prdata[31:5] == 0) else $error("index");
  a_arb_onehot: assert property (rd && paddr == 'h10 |=> $onehot0(prdata)) else $error("arb");
  // main scenarios
  cover property ($rose(normal_irq));
  cover property ($rose(fast_irq));
  cover property (pready && pslverr);
endmodule
bind rpic_top rpic_chk #(.ADDR_W(ADDR_W)) rpic_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fast_irq(fast_irq), .normal_irq(normal_irq));
`default_nettype wire

// File: dv/rpic_core_model.sv
/* core side model: counts new fast and normal requests.
   assumes the pclk domain. */
`timescale 1ns/100ps
`default_nettype none
module rpic_core_model
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic fast_irq, // fast request
  input wire logic normal_irq, // normal request
  output logic [7:0] n_fast, // fast rises
  output logic [7:0] n_norm // normal rises
);
  logic f_q, n_q;
  // count rising requests on each line
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {f_q, n_q, n_fast, n_norm} <= '0;
    end
    else
    begin
      f_q <= fast_irq;
      n_q <= normal_irq;
      if (fast_irq && !f_q) n_fast <= n_fast + 8'h01;
      if (normal_irq && !n_q) n_norm <= n_norm + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
/* testbench for rpic_top: apb master, source pulses, core model.
   assumes rpic_top and rpic_core_model as declared. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic serial_err0 = 0, serial_err1 = 0, pready, pslverr, fast_irq, normal_irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, src_req = '0, prdata, rd;
  logic [7:0] n_fast, n_norm;
  int err_count = 0, checked = 0, cyc = 0;
  rpic_top rpic_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .serial_err0(serial_err0),
    .serial_err1(serial_err1), .fast_irq(fast_irq), .normal_irq(normal_irq));
  rpic_core_model rpic_core_model_i (.pclk(pclk), .presetn(presetn), .fast_irq(fast_irq),
    .normal_irq(normal_irq), .n_fast(n_fast), .n_norm(n_norm));
  initial forever #2 pclk = ~pclk;
  // hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic serve(input int b);
    apb(1'b1, 12'h000, 32'h1 << b);
    apb(1'b1, 12'h010, 32'h1 << b);
  endtask
  task automatic pulse(input logic [31:0] m);
    @(posedge pclk);
    src_req <= m;
    @(posedge pclk);
    src_req <= '0;
  endtask
  task automatic t_reset();
    rdchk(12'h008, 32'hffffffff);
    rdchk(12'h000, 32'h0);
    rdchk(12'h004, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk(er, 1);
    $display("reset test done");
  endtask
  task automatic t_mask();
    pulse(32'h20);
    rdchk(12'h000, 32'h20);
    rdchk(12'h010, 32'h0);
    apb(1'b1, 12'h008, ~32'h3f0);
    rdchk(12'h010, 32'h20);
    rdchk(12'h014, 32'h5);
    chk(normal_irq, 1);
    apb(1'b1, 12'h010, 32'h20);
    rdchk(12'h010, 32'h20);
    serve(5);
    rdchk(12'h000, 32'h0);
    repeat (3) @(posedge pclk);
    chk(normal_irq, 0);
    $display("mask test done");
  endtask
  task automatic t_order();
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 12'h00c, 32'(s) << 10);
      pulse(32'h1e0);
      rdchk(12'h014, 32'(5 + s));
      apb(1'b1, 12'h000, 32'h1e0);
      apb(1'b1, 12'h010, 32'h20 << s);
      rdchk(12'h00c, 32'(s) << 10);
    end
    $display("order test done");
  endtask
  task automatic t_rot();
    int w[5] = '{4, 5, 6, 8, 9};
    logic [31:0] p[5] = '{32'h2, 32'h402, 32'h802, 32'h2, 32'h2};
    apb(1'b1, 12'h00c, 32'h2);
    pulse(32'h370);
    for (int i = 0; i < 5; i++)
    begin
      rdchk(12'h014, 32'(w[i]));
      rdchk(12'h00c, p[i]);
      serve(w[i]);
    end
    $display("rotate test done");
  endtask
  task automatic t_fast();
    apb(1'b1, 12'h004, 32'h8);
    rdchk(12'h004, 32'h0);
    apb(1'b1, 12'h008, ~32'h8);
    pulse(32'h8);
    repeat (2) @(posedge pclk);
    chk(fast_irq, 1);
    rdchk(12'h010, 32'h0);
    chk(normal_irq, 0);
    apb(1'b1, 12'h000, 32'h8);
    repeat (2) @(posedge pclk);
    chk(fast_irq, 0);
    serial_err0 <= 1'b1;
    @(posedge pclk);
    serial_err0 <= 1'b0;
    rdchk(12'h000, 32'h8000);
    apb(1'b1, 12'h000, 32'h8000);
    serial_err1 <= 1'b1;
    @(posedge pclk);
    serial_err1 <= 1'b0;
    rdchk(12'h000, 32'h8000);
    chk(n_fast, 1);
    chk(n_norm, 32'h0000000b);
    $display("fast test done");
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_order();
    t_rot();
    t_fast();
    wrap_up();
  end
endmodule
`default_nettype wire
